/* logic/usart_ctrl_pkg.sv */
// Function
// RL1 - Start-break write waits until holding and shift registers have fully emptied.
// RL2 - Stop-break ends break after one character time, then 12 high bit periods.
// RL3 - Arm-timeout write makes receiver wait for a character before counting.
// RL4 - Send-address in multi-drop mode sets address bit on next written character.
// RL5 - Baud source: 00 master clock, 01 master clock over 8, 1x external clock.
// RL6 - Character length code selects 5 to 8 data bits, framing bits extra.
// RL7 - Sync select 0 means asynchronous, 1 means synchronous operation.
// RL8 - Parity field: even, odd, space, mark, none, or multi-drop.
// RL9 - Stop bits: 00 one, 10 two, 01 one-and-half async only, 11 reserved.
// RL10 - Test mode 00 normal; 01 echoes received input onto serial output.
// RL11 - Test mode 10 loops transmitter to receiver; 11 ties input pin to output.
// RL12 - Nine-bit select forces 9-bit characters, else length code applies.
// RL13 - Serial clock pin driven only when drive bit set and source upper bit clear.
// RL14 - Enable-set writes of 1 enable matching sources; zeros have no effect.
// RL15 - Enable-clear writes of 1 disable matching sources; zeros have no effect.
// RL16 - Enable-state register reads back the accumulated enable of each source.
// RL17 - Debug channel enable bits 30 and 31 exist only on first instance.
// RL18 - Interrupt output asserts when any flag is set with its enable set.
// RL19 - Software never requests start-break and stop-break in one command write.
// RL20 - Unused bits of command, mode and interrupt registers ignore writes, read zero.
package usart_ctrl_pkg;
    localparam logic [7:0] OFS_COMMAND = 8'h00;
    localparam logic [7:0] OFS_FRAME = 8'h04;
    localparam logic [7:0] OFS_IRQ_SET = 8'h08;
    localparam logic [7:0] OFS_IRQ_CLR = 8'h0C;
    localparam logic [7:0] OFS_IRQ_STATE = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;
    localparam int CMD_BEGIN_BREAK = 9;
    localparam int CMD_END_BREAK = 10;
    localparam int CMD_ARM_TIMEOUT = 11;
    localparam int CMD_SEND_ADDRESS = 12;
    localparam int FRAME_LSB = 4;
    localparam int FRAME_MSB = 18;
    localparam int STAT_TX_HOLDING_FREE = 1;
    localparam int STAT_TX_ALL_EMPTY = 9;
    localparam logic [31:0] IRQ_BITS_ALL = 32'hC00003FF;
    localparam logic [31:0] IRQ_BITS_NO_DEBUG = 32'h000003FF;
    localparam logic [31:0] RESET_WORD = 32'h00000000;
    localparam logic [3:0] BREAK_MARK_BITS = 4'hC;
    localparam logic [2:0] DIV8_LAST = 3'h7;
    localparam logic [1:0] TEST_NORMAL = 2'h0;
    localparam logic [1:0] TEST_ECHO = 2'h1;
    localparam logic [1:0] TEST_LOCAL = 2'h2;
    localparam logic [1:0] TEST_REMOTE = 2'h3;
    localparam logic [1:0] SRC_MASTER = 2'h0;
    localparam logic [1:0] SRC_MASTER_DIV8 = 2'h1;
    localparam logic [3:0] CHAR_BITS_MIN = 4'h5;
    localparam logic [3:0] CHAR_BITS_NINE = 4'h9;

    typedef struct packed {
        logic serial_clock_drive;
        logic nine_bit_char;
        logic spare;
        logic [1:0] channel_test_mode;
        logic [1:0] stop_bit_count;
        logic [2:0] parity_type;
        logic sync_mode_select;
        logic [1:0] char_length_code;
        logic [1:0] baud_clock_source;
    } frame_cfg_s;

    typedef enum logic [3:0] {
        BRK_IDLE = 4'h1,
        BRK_WAIT = 4'h2,
        BRK_LOW = 4'h4,
        BRK_MARK = 4'h8
    } break_state_e;
endpackage : usart_ctrl_pkg

/* logic/usart_clock_select.sv */
`timescale 1ns/1ps
`default_nettype none
module usart_clock_select (
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Configuration
    input wire logic [1:0] baud_clock_source,
    input wire logic serial_clock_drive,
    // Serial clock pin
    input wire logic sclk_in,
    output logic sclk_out,
    output logic sclk_oe,
    // Baud generator input tick
    output logic baud_tick
);
    typedef struct packed {
        logic [2:0] div_cnt;
        logic sync1;
        logic sync2;
        logic prev;
        logic tick;
        logic sclk_q;
        logic oe;
    } clk_state_s;

    clk_state_s st_reg;
    clk_state_s st_next;

    always_comb
    begin
        st_next = st_reg;
        st_next.div_cnt = st_reg.div_cnt + 3'h1;
        st_next.sync1 = sclk_in;
        st_next.sync2 = st_reg.sync1;
        st_next.prev = st_reg.sync2;
        // The external clock is sampled, so it must run well below half of mclk.
        case (baud_clock_source) // [RL5]
            usart_ctrl_pkg::SRC_MASTER:
            begin
                st_next.tick = 1'b1;
                st_next.sclk_q = ~st_reg.sclk_q;
            end
            usart_ctrl_pkg::SRC_MASTER_DIV8:
            begin
                st_next.tick = (st_reg.div_cnt == usart_ctrl_pkg::DIV8_LAST);
                st_next.sclk_q = st_reg.div_cnt[2];
            end
            default:
            begin
                st_next.tick = st_reg.sync2 & ~st_reg.prev;
                st_next.sclk_q = 1'b0;
            end
        endcase
        st_next.oe = serial_clock_drive & ~baud_clock_source[1]; // [RL13]
    end

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end

    assign baud_tick = st_reg.tick;
    assign sclk_out = st_reg.sclk_q;
    assign sclk_oe = st_reg.oe;

    a_sclk_gate: assert property (@(posedge mclk) disable iff (sys_rst)
        baud_clock_source[1] |=> !sclk_oe) // [RL13]
        else $error("serial clock driven while external source selected");
    a_div8_gap: assert property (@(posedge mclk) disable iff (sys_rst)
        (baud_clock_source == 2'h1 && $stable(baud_clock_source) && baud_tick)
        ##1 (baud_clock_source == 2'h1)
        |-> !baud_tick) // [RL5]
        else $error("divided tick came too soon");
endmodule : usart_clock_select
`default_nettype wire

/* logic/usart_break_seq.sv */
`timescale 1ns/1ps
`default_nettype none
module usart_break_seq (
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Commands
    input wire logic begin_req,
    input wire logic end_req,
    // Transmitter state
    input wire logic tx_idle,
    input wire logic bit_tick,
    input wire logic [3:0] frame_bits,
    // Break state
    output logic line_low,
    output logic busy,
    output logic pending
);
    typedef struct packed {
        usart_ctrl_pkg::break_state_e state;
        logic [3:0] bit_cnt;
        logic min_done;
        logic stop_seen;
    } brk_state_s;

    brk_state_s st_reg;
    brk_state_s st_next;

    always_comb
    begin
        st_next = st_reg;
        case (st_reg.state)
            usart_ctrl_pkg::BRK_IDLE:
            begin
                // A stop without a started break is ignored.
                if (begin_req)
                    st_next.state = usart_ctrl_pkg::BRK_WAIT;
            end
            usart_ctrl_pkg::BRK_WAIT:
            begin
                if (tx_idle) // [RL1]
                begin
                    st_next.state = usart_ctrl_pkg::BRK_LOW;
                    st_next.bit_cnt = 4'h0;
                    st_next.min_done = 1'b0;
                    st_next.stop_seen = 1'b0;
                end
            end
            usart_ctrl_pkg::BRK_LOW:
            begin
                if (end_req)
                    st_next.stop_seen = 1'b1;
                if (bit_tick && !st_reg.min_done)
                begin
                    st_next.bit_cnt = st_reg.bit_cnt + 4'h1;
                    if (st_reg.bit_cnt + 4'h1 >= frame_bits)
                        st_next.min_done = 1'b1;
                end
                if (st_reg.min_done && (st_reg.stop_seen || end_req)) // [RL2]
                begin
                    st_next.state = usart_ctrl_pkg::BRK_MARK;
                    st_next.bit_cnt = 4'h0;
                end
            end
            usart_ctrl_pkg::BRK_MARK:
            begin
                if (bit_tick)
                begin
                    st_next.bit_cnt = st_reg.bit_cnt + 4'h1;
                    if (st_reg.bit_cnt + 4'h1 == usart_ctrl_pkg::BREAK_MARK_BITS) // [RL2]
                        st_next.state = usart_ctrl_pkg::BRK_IDLE;
                end
            end
            default:
                st_next.state = usart_ctrl_pkg::BRK_IDLE;
        endcase
    end

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            st_reg.state <= usart_ctrl_pkg::BRK_IDLE;
            st_reg.bit_cnt <= 4'h0;
            st_reg.min_done <= 1'b0;
            st_reg.stop_seen <= 1'b0;
        end
        else
            st_reg <= st_next;
    end

    assign line_low = (st_reg.state == usart_ctrl_pkg::BRK_LOW);
    assign busy = (st_reg.state != usart_ctrl_pkg::BRK_IDLE);
    assign pending = (st_reg.state == usart_ctrl_pkg::BRK_WAIT);

    a_break_waits: assert property (@(posedge mclk) disable iff (sys_rst)
        (st_reg.state == usart_ctrl_pkg::BRK_WAIT && !tx_idle) |=> pending) // [RL1]
        else $error("break started before transmitter emptied");
    a_min_char: assert property (@(posedge mclk) disable iff (sys_rst)
        (line_low && !st_reg.min_done) |=> !(st_reg.state == usart_ctrl_pkg::BRK_MARK))
        // [RL2]
        else $error("break ended before one character time");
    a_mark_end: assert property (@(posedge mclk) disable iff (sys_rst)
        (st_reg.state == usart_ctrl_pkg::BRK_MARK && bit_tick && st_reg.bit_cnt == 4'hB)
        |=> !busy) // [RL2]
        else $error("mark period not twelve bits");
endmodule : usart_break_seq
`default_nettype wire

/* logic/usart_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
module usart_ctrl #(
    parameter bit FIRST_INSTANCE = 1'b1
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    // Channel status and transmitter handshakes
    input wire logic [31:0] status_flags,
    input wire logic tx_idle,
    input wire logic tx_char_written,
    input wire logic tx_serial,
    // Serial pins
    input wire logic serial_in_pin,
    output logic serial_out_pin,
    input wire logic sclk_in,
    output logic sclk_out,
    output logic sclk_oe,
    // Receiver and transmitter controls
    output logic rx_serial,
    output logic baud_tick,
    output logic rx_timeout_arm,
    output logic tx_address_bit,
    output logic [3:0] char_data_bits,
    output usart_ctrl_pkg::frame_cfg_s frame_cfg,
    output logic stop_code_reserved,
    output logic break_active,
    output logic irq
);
    typedef struct packed {
        logic dphase_wr;
        logic [7:0] dphase_addr;
        logic ready;
        logic [31:0] rdata;
        usart_ctrl_pkg::frame_cfg_s cfg;
        logic [31:0] irq_mask;
        logic irq;
        logic arm_pulse;
        logic addr_pending;
        logic serial_out;
        logic rx_serial;
        logic [3:0] data_bits;
        logic [3:0] frame_bits;
        logic stop_reserved;
    } ctrl_state_s;

    localparam logic [31:0] IRQ_IMPL = FIRST_INSTANCE ? usart_ctrl_pkg::IRQ_BITS_ALL
                                                      : usart_ctrl_pkg::IRQ_BITS_NO_DEBUG;

    ctrl_state_s st_reg;
    ctrl_state_s st_next;

    logic brk_low;
    logic brk_busy;
    logic brk_pending;
    logic begin_req;
    logic end_req;
    logic wr_cmd;
    logic multidrop;
    logic [31:0] status_eff;

    // Break status overrides the transmitter's own empty and ready flags.
    always_comb
    begin
        status_eff = status_flags;
        if (brk_busy)
            status_eff[usart_ctrl_pkg::STAT_TX_ALL_EMPTY] = 1'b0;
        if (brk_pending)
            status_eff[usart_ctrl_pkg::STAT_TX_HOLDING_FREE] = 1'b0;
        status_eff = status_eff & IRQ_IMPL;
    end

    assign wr_cmd = st_reg.dphase_wr && (st_reg.dphase_addr == usart_ctrl_pkg::OFS_COMMAND);
    // Both break commands in one write is undefined; dropping both keeps state sane.
    assign begin_req = wr_cmd && hwdata[usart_ctrl_pkg::CMD_BEGIN_BREAK]
                       && !hwdata[usart_ctrl_pkg::CMD_END_BREAK]; // [RL19]
    assign end_req = wr_cmd && hwdata[usart_ctrl_pkg::CMD_END_BREAK]
                     && !hwdata[usart_ctrl_pkg::CMD_BEGIN_BREAK];
    assign multidrop = (st_reg.cfg.parity_type[2:1] == 2'h3); // [RL8]

    usart_break_seq u_break (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .begin_req(begin_req),
        .end_req(end_req),
        .tx_idle(tx_idle),
        .bit_tick(baud_tick),
        .frame_bits(st_reg.frame_bits),
        .line_low(brk_low),
        .busy(brk_busy),
        .pending(brk_pending)
    );

    usart_clock_select u_clock (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .baud_clock_source(st_reg.cfg.baud_clock_source),
        .serial_clock_drive(st_reg.cfg.serial_clock_drive),
        .sclk_in(sclk_in),
        .sclk_out(sclk_out),
        .sclk_oe(sclk_oe),
        .baud_tick(baud_tick)
    );

    always_comb
    begin
        st_next = st_reg;
        st_next.ready = 1'b1;
        st_next.arm_pulse = 1'b0;

        // Address phase: capture the transfer and prepare read data one cycle ahead.
        st_next.dphase_wr = 1'b0;
        if (hsel && htrans[1] && hready)
        begin
            st_next.dphase_wr = hwrite;
            st_next.dphase_addr = haddr[7:0];
            st_next.rdata = usart_ctrl_pkg::RESET_WORD;
            if (!hwrite)
            begin
                case (haddr[7:0])
                    usart_ctrl_pkg::OFS_FRAME:
                        st_next.rdata = {13'h0000, st_reg.cfg, 4'h0}; // [RL20]
                    usart_ctrl_pkg::OFS_IRQ_STATE:
                        st_next.rdata = st_reg.irq_mask; // [RL16]
                    usart_ctrl_pkg::OFS_STATUS:
                        st_next.rdata = status_eff;
                    default:
                        st_next.rdata = usart_ctrl_pkg::RESET_WORD;
                endcase
            end
        end

        // Data phase writes.
        if (st_reg.dphase_wr)
        begin
            case (st_reg.dphase_addr)
                usart_ctrl_pkg::OFS_COMMAND:
                begin
                    st_next.arm_pulse = hwdata[usart_ctrl_pkg::CMD_ARM_TIMEOUT]; // [RL3]
                end
                usart_ctrl_pkg::OFS_FRAME:
                begin
                    st_next.cfg = hwdata[usart_ctrl_pkg::FRAME_MSB:usart_ctrl_pkg::FRAME_LSB];
                    st_next.cfg.spare = 1'b0; // [RL20]
                end
                usart_ctrl_pkg::OFS_IRQ_SET:
                    st_next.irq_mask = st_reg.irq_mask | (hwdata & IRQ_IMPL); // [RL14] [RL17]
                usart_ctrl_pkg::OFS_IRQ_CLR:
                    st_next.irq_mask = st_reg.irq_mask & ~(hwdata & IRQ_IMPL); // [RL15]
                default:
                    st_next.irq_mask = st_reg.irq_mask;
            endcase
        end

        // The address flag is cleared by a transmitted write, but a new request wins.
        if (tx_char_written)
            st_next.addr_pending = 1'b0;
        if (!multidrop)
            st_next.addr_pending = 1'b0;
        if (wr_cmd && hwdata[usart_ctrl_pkg::CMD_SEND_ADDRESS] && multidrop) // [RL4]
            st_next.addr_pending = 1'b1;

        st_next.irq = |(status_eff & st_reg.irq_mask); // [RL18]

        // Character and frame length for the shifters and the break timer.
        if (st_reg.cfg.nine_bit_char) // [RL12]
            st_next.data_bits = usart_ctrl_pkg::CHAR_BITS_NINE;
        else
            st_next.data_bits = usart_ctrl_pkg::CHAR_BITS_MIN
                                + {2'h0, st_reg.cfg.char_length_code}; // [RL6]
        st_next.frame_bits = 4'h1 + st_reg.data_bits
                             + {3'h0, st_reg.cfg.parity_type[2:1] != 2'h2}
                             + ((st_reg.cfg.stop_bit_count == 2'h0) ? 4'h1 : 4'h2);
        // One-and-a-half stop bits exist only without a shared clock.
        st_next.stop_reserved = (st_reg.cfg.stop_bit_count == 2'h3)
                                || (st_reg.cfg.stop_bit_count == 2'h1
                                    && st_reg.cfg.sync_mode_select); // [RL9] [RL7]

        // Pin routing; the receiver sees an idle high line in remote loopback.
        case (st_reg.cfg.channel_test_mode)
            usart_ctrl_pkg::TEST_NORMAL:
            begin
                st_next.serial_out = brk_low ? 1'b0 : (brk_busy ? 1'b1 : tx_serial); // [RL10]
                st_next.rx_serial = serial_in_pin;
            end
            usart_ctrl_pkg::TEST_ECHO:
            begin
                st_next.serial_out = serial_in_pin; // [RL10]
                st_next.rx_serial = serial_in_pin;
            end
            usart_ctrl_pkg::TEST_LOCAL:
            begin
                st_next.serial_out = 1'b1; // [RL11]
                st_next.rx_serial = brk_low ? 1'b0 : tx_serial;
            end
            default:
            begin
                st_next.serial_out = serial_in_pin; // [RL11]
                st_next.rx_serial = 1'b1;
            end
        endcase
    end

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            st_reg <= '0;
            st_reg.serial_out <= 1'b1;
            st_reg.rx_serial <= 1'b1;
            st_reg.data_bits <= usart_ctrl_pkg::CHAR_BITS_MIN;
            st_reg.frame_bits <= 4'h7;
        end
        else
            st_reg <= st_next;
    end

    assign hreadyout = st_reg.ready;
    assign hrdata = st_reg.rdata;
    assign hresp = 1'b0;
    assign irq = st_reg.irq;
    assign rx_timeout_arm = st_reg.arm_pulse;
    assign tx_address_bit = st_reg.addr_pending;
    assign char_data_bits = st_reg.data_bits;
    assign frame_cfg = st_reg.cfg;
    assign stop_code_reserved = st_reg.stop_reserved;
    assign serial_out_pin = st_reg.serial_out;
    assign rx_serial = st_reg.rx_serial;
    assign break_active = brk_busy;

    a_mask_set: assert property (@(posedge mclk) disable iff (sys_rst)
        (st_reg.dphase_wr && st_reg.dphase_addr == 8'h08 && hwdata[0]) |=> st_reg.irq_mask[0])
        // [RL14]
        else $error("enable-set did not enable source");
    a_mask_clear: assert property (@(posedge mclk) disable iff (sys_rst)
        (st_reg.dphase_wr && st_reg.dphase_addr == 8'h0C && hwdata[9]) |=> !st_reg.irq_mask[9])
        // [RL15]
        else $error("enable-clear did not disable source");
    a_mask_hold: assert property (@(posedge mclk) disable iff (sys_rst)
        !st_reg.dphase_wr |=> $stable(st_reg.irq_mask)) // [RL16]
        else $error("enable state changed without a write");
    a_irq_follows: assert property (@(posedge mclk) disable iff (sys_rst)
        (|(status_flags & st_reg.irq_mask & 32'h000001FD)) |=> irq) // [RL18]
        else $error("interrupt missing for enabled flag");
    a_debug_bits: assert property (@(posedge mclk) disable iff (sys_rst)
        !FIRST_INSTANCE |-> st_reg.irq_mask[31:30] == 2'h0) // [RL17]
        else $error("debug enable bits present on later instance");
    a_arm_pulse: assert property (@(posedge mclk) disable iff (sys_rst)
        (wr_cmd && hwdata[11]) |=> rx_timeout_arm ##1 !rx_timeout_arm) // [RL3]
        else $error("time-out arm not a single pulse");
    a_addr_md_only: assert property (@(posedge mclk) disable iff (sys_rst)
        !multidrop |=> !tx_address_bit) // [RL4]
        else $error("address bit set outside multi-drop");
    a_echo_route: assert property (@(posedge mclk) disable iff (sys_rst)
        (st_reg.cfg.channel_test_mode == 2'h1) |=> serial_out_pin == $past(serial_in_pin))
        // [RL10]
        else $error("echo mode not routing input to output");
    a_cfg_spare: assert property (@(posedge mclk) disable iff (sys_rst)
        frame_cfg.spare == 1'b0) // [RL20]
        else $error("unused mode bit stored");
    a_nine_bits: assert property (@(posedge mclk) disable iff (sys_rst)
        st_reg.cfg.nine_bit_char |=> char_data_bits == 4'h9) // [RL12]
        else $error("nine-bit length not applied");
endmodule : usart_ctrl
`default_nettype wire

/* verif/remote_serial_dev.sv */
`timescale 1ns/1ps
`default_nettype none
module remote_serial_dev #(
    parameter int BIT_CYC = 10
) (
    // Clock
    input wire logic mclk,
    // Frame request
    input wire logic start,
    input wire logic [7:0] data,
    // Receive line of the block
    output logic serial_in_pin
);
    logic [9:0] frame = 10'h3FF;
    int bits = 0;
    int cnt = 0;
    initial serial_in_pin = 1'b1;
    // Start bit, eight data bits first bit first, then a stop bit; idle high between frames.
    always @(posedge mclk)
    begin
        if (start)
        begin
            frame <= {1'b1, data, 1'b0};
            bits <= 10;
            cnt <= 0;
        end
        else if (bits != 0)
        begin
            serial_in_pin <= frame[0];
            cnt <= (cnt == BIT_CYC - 1) ? 0 : cnt + 1;
            if (cnt == BIT_CYC - 1)
            begin
                frame <= {1'b1, frame[9:1]};
                bits <= bits - 1;
            end
        end
        else
            serial_in_pin <= 1'b1;
    end
endmodule : remote_serial_dev
`default_nettype wire

/* verif/usart_command_mode_irq_regs_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module usart_command_mode_irq_regs_tb;
    logic mclk = 1'b0, sys_rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, rd = 1'b0, start = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, status_flags = 32'h0, v;
    logic [1:0] htrans = 2'h0;
    logic [7:0] pdata = 8'h0;
    logic [3:0] char_data_bits, sdiv = 4'h0;
    logic tx_idle = 1'b1, tx_char_written = 1'b0, tx_serial = 1'b1, sclk_in;
    logic hreadyout, serial_in_pin, serial_out_pin, sclk_oe, rx_serial, baud_tick;
    logic tx_address_bit, break_active, irq, eo, er, rx_timeout_arm, stop_code_reserved;
    logic [31:0] exp_q[$];
    int seed = 32'hD2F4;
    int n_errors = 0, check_count = 0, i, n, hi;
    assign sclk_in = sdiv[3];
    always #12.5 mclk = ~mclk;
    always @(posedge mclk) sdiv <= sdiv + 4'h1;
    usart_ctrl dut (.mclk, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
        .hready(hreadyout), .hreadyout, .hrdata, .hresp(), .status_flags, .tx_idle,
        .tx_char_written, .tx_serial, .serial_in_pin, .serial_out_pin, .sclk_in, .sclk_out(),
        .sclk_oe, .rx_serial, .baud_tick, .rx_timeout_arm, .tx_address_bit, .char_data_bits,
        .frame_cfg(), .stop_code_reserved, .break_active, .irq);
    remote_serial_dev partner (.mclk, .start, .data(pdata), .serial_in_pin);
    task check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task print_verdict;
        $display("checks=%0d mismatches=%0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : print_verdict
    task limit_hit(input int c, input int lim);
        if (c >= lim)
        begin
            n_errors++;
            print_verdict();
        end
    endtask : limit_hit
    task cyc(input int c);
        repeat (c) @(posedge mclk);
    endtask : cyc
    task wait_rdy;
        int k;
        k = 0;
        @(posedge mclk);
        while (hreadyout !== 1'b1 && k < 100)
        begin
            @(posedge mclk);
            k++;
        end
        limit_hit(k, 100);
    endtask : wait_rdy
    // Entered just after a rising edge; the address phase stands until hready is seen high.
    task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        rd <= ~wr;
        wait_rdy();
        rd <= 1'b0;
    endtask : bus
    task rd_exp(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask : rd_exp
    // Read data is judged at the edge that closes the data phase, oldest note first.
    always @(posedge mclk)
        if (rd === 1'b1 && hreadyout === 1'b1 && exp_q.size() > 0)
            check(hrdata, exp_q.pop_front());
    initial
    begin
        cyc(3);
        sys_rst <= 1'b0;
        @(posedge mclk);
        rd_exp(8'h04, 32'h0);
        rd_exp(8'h10, 32'h0);
        v = $random(seed);
        bus(1'b1, 8'h04, v);
        rd_exp(8'h04, v & 32'h0006FFF0);
        rd_exp(8'h00, 32'h0);
        rd_exp(8'h40, 32'h0);
        $display("test registers done");
        bus(1'b1, 8'h08, 32'hFFFFFFFF);
        rd_exp(8'h10, 32'hC00003FF);
        bus(1'b1, 8'h0C, 32'h0000000F);
        rd_exp(8'h10, 32'hC00003F0);
        status_flags <= 32'h1;
        cyc(4);
        check({31'h0, irq}, 32'h0);
        status_flags <= 32'h10;
        cyc(4);
        check({31'h0, irq}, 32'h1);
        status_flags <= 32'h0;
        $display("test interrupts done");
        for (i = 0; i < 4; i++)
        begin
            bus(1'b1, 8'h04, 32'(i) << 6);
            cyc(3);
            check({28'h0, char_data_bits}, 32'(5 + i));
        end
        bus(1'b1, 8'h04, 32'h20000);
        cyc(3);
        check({28'h0, char_data_bits}, 32'h9);
        for (i = 0; i < 3; i++)
        begin
            bus(1'b1, 8'h04, (32'(i) << 4) | 32'h40000);
            cyc(4);
            check({31'h0, sclk_oe}, {31'h0, i < 2});
            n = 0;
            repeat (64)
            begin
                @(posedge mclk);
                if (baud_tick === 1'b1)
                    n++;
            end
            check(n, (i == 0) ? 64 : (i == 1) ? 8 : 4);
        end
        $display("test clocking done");
        for (i = 0; i < 4; i++)
        begin
            bus(1'b1, 8'h04, 32'(i) << 14);
            v = $random(seed);
            pdata <= v[7:0];
            start <= 1'b1;
            @(posedge mclk);
            start <= 1'b0;
            repeat (10)
            begin
                tx_serial <= 1'($random(seed));
                cyc(8);
                eo = (i == 0) ? tx_serial : (i == 2) ? 1'b1 : serial_in_pin;
                er = (i < 2) ? serial_in_pin : (i == 2) ? tx_serial : 1'b1;
                check({30'h0, serial_out_pin, rx_serial}, {30'h0, eo, er});
                cyc(2);
            end
        end
        $display("test channel modes done");
        bus(1'b1, 8'h04, 32'h1C00);
        bus(1'b1, 8'h00, 32'h1000);
        cyc(3);
        check({31'h0, tx_address_bit}, 32'h1);
        check({31'h0, stop_code_reserved}, 32'h0);
        tx_char_written <= 1'b1;
        @(posedge mclk);
        tx_char_written <= 1'b0;
        cyc(3);
        check({31'h0, tx_address_bit}, 32'h0);
        bus(1'b1, 8'h04, 32'h1100);
        bus(1'b1, 8'h00, 32'h1000);
        cyc(3);
        check({31'h0, tx_address_bit}, 32'h0);
        check({31'h0, stop_code_reserved}, 32'h1);
        bus(1'b1, 8'h00, 32'h800);
        cyc(1);
        check({31'h0, rx_timeout_arm}, 32'h1);
        cyc(1);
        check({31'h0, rx_timeout_arm}, 32'h0);
        $display("test address flag done");
        tx_serial <= 1'b1;
        tx_idle <= 1'b0;
        bus(1'b1, 8'h00, 32'h200);
        cyc(20);
        check({30'h0, break_active, serial_out_pin}, 32'h3);
        tx_idle <= 1'b1;
        n = 0;
        while (serial_out_pin !== 1'b0 && n < 50)
        begin
            @(posedge mclk);
            n++;
        end
        limit_hit(n, 50);
        cyc(30);
        check({31'h0, serial_out_pin}, 32'h0);
        bus(1'b1, 8'h00, 32'h400);
        n = 0;
        hi = 0;
        while (break_active !== 1'b0 && n < 200)
        begin
            @(posedge mclk);
            n++;
            if (serial_out_pin === 1'b1)
                hi++;
        end
        limit_hit(n, 200);
        // The registered pin trails the sequencer by a cycle, so all twelve high bits are seen.
        check({30'h0, serial_out_pin, hi >= 12}, 32'h3);
        $display("test break done");
        print_verdict();
    end
endmodule : usart_command_mode_irq_regs_tb
`default_nettype wire
